//--- nbu_cfg.svh
`ifndef NBU_CFG_SVH
`define NBU_CFG_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define NBU_ADDR_W          12
`define NBU_IDX_POWER       10'h087
`define NBU_IDX_CONTROL     10'h098
`define NBU_IDX_BUFFER      10'h099
`define NBU_IDX_OWN_ADDR    10'h0a9
`define NBU_IDX_OWN_MASK    10'h0b9
`define NBU_IDX_BAUD_SRC    10'h0c9

// ****************************************
// Field positions
// ****************************************
`define NBU_CTL_MODE_HI     7
`define NBU_CTL_MODE_LO     6
`define NBU_CTL_MPE         5
`define NBU_CTL_REN         4
`define NBU_CTL_TB8         3
`define NBU_CTL_RB8         2
`define NBU_CTL_TI          1
`define NBU_CTL_RI          0
`define NBU_PWR_DOUBLE      7
`define NBU_PWR_FE_VIEW     6
`define NBU_SRC_TX_T2       0
`define NBU_SRC_RX_T2       1

// ****************************************
// Reset values and timing counts
// ****************************************
`define NBU_RST_BYTE        8'h00
`define NBU_RX_PRELOAD      9'h1ff
`define NBU_OVS_LAST        4'hf
`define NBU_SAMPLE_A        4'h7
`define NBU_SAMPLE_B        4'h8
`define NBU_SAMPLE_C        4'h9

`endif

//--- nbu_pkg.sv
package nbu_pkg;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_8BIT  = 2'b01,
        MODE_9FIX  = 2'b10,
        MODE_9VAR  = 2'b11
    } nbu_mode_type;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_WAIT  = 4'b0010,
        TX_START = 4'b0100,
        TX_DATA  = 4'b1000
    } nbu_tx_state_type;

    typedef enum logic [2:0] {
        RX_HUNT = 3'b001,
        RX_BITS = 3'b010,
        RX_STOP = 3'b100
    } nbu_rx_state_type;

endpackage

//--- nbu_uart.sv
// Our own choice: the APB slave port.
`include "nbu_cfg.svh"

// What this block does
// - Frame: start, eight data LSB first, ninth, stop.
// - Transmit sends software-chosen ninth bit.
// - Mode 2 rate is oscillator /16 or /32.
// - Mode 3 rate from selected timer overflows.
// - Buffer write loads ninth bit, starts after rollover.
// - Start bit, then data, first shift adds stop.
// - Last shift ends send, sets transmit done flag.
// - Falling edge resets counter, preloads all ones.
// - Majority of samples seven, eight, nine.
// - Nonzero start bit aborts, hunt again.
// - Start reaching end triggers final shift.
// - Load only if flag clear and ninth allowed.
// - Store ninth and data; hunt at once in mode 1, one bit later otherwise.
// - Low stop bit sets frame error; mode 1 stores stop bit as ninth.
// - Missing stop bit always sets frame error.
// - Control bit 7 shows error or mode bit.
// - Only software clears frame error flag.
// - Address recognition in modes 1-3, not 0.
// - Nine-bit modes: ninth set and address match.
// - Mode 1: valid stop and address match.
// - Given address uses mask as care bits.
// - Broadcast is address OR mask, zeros ignored.
// - Address and mask reset to zero.
module nbu_uart (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    // APB slave
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [`NBU_ADDR_W-1:0]  i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic      [31:0]             o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr,
    // Baud sources
    input  wire logic                    i_timer1_ovf,
    input  wire logic                    i_timer2_ovf,
    // Serial line
    input  wire logic                    i_rxd,
    output logic                         o_txd
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic idx_is(input logic [`NBU_ADDR_W-1:0] addr,
                                    input logic [9:0] idx);
        idx_is = (addr[`NBU_ADDR_W-1:2] == idx);
    endfunction

    function automatic logic addr_match(input logic [7:0] rx_byte,
                                        input logic [7:0] own,
                                        input logic [7:0] mask);
        logic given_ok;
        logic bcast_ok;
        given_ok   = (((rx_byte ^ (own & mask)) & mask) == 8'h00);
        bcast_ok   = (((~rx_byte) & (own | mask)) == 8'h00);
        addr_match = given_ok | bcast_ok;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]                   own_address_value_r;
    logic [7:0]                   own_address_mask_r;
    logic                         mode_hi_r;
    logic                         mode_lo_r;
    logic                         mpe_r;
    logic                         ren_r;
    logic                         tb8_r;
    logic                         rb8_r;
    logic                         ti_r;
    logic                         ri_r;
    logic                         fe_r;
    logic                         fe_view_r;
    logic                         double_r;
    logic                         tx_t2_r;
    logic                         rx_t2_r;
    logic [7:0]                   rx_buf_r;
    logic [31:0]                  prdata_r;

    logic                         wr_en;
    logic                         addr_hit;
    logic [7:0]                   rd_mux;
    logic [7:0]                   ctrl_view;
    nbu_pkg::nbu_mode_type        mode;

    assign mode  = nbu_pkg::nbu_mode_type'({mode_hi_r, mode_lo_r});
    assign wr_en = i_psel & i_penable & i_pwrite;

    // ****************************************
    // APB decode and read path
    // ****************************************
    assign ctrl_view = {fe_view_r ? fe_r : mode_hi_r,
                        mode_lo_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};

    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 8'h00;
        if (idx_is(i_paddr, `NBU_IDX_CONTROL)) begin
            rd_mux = ctrl_view;
        end else if (idx_is(i_paddr, `NBU_IDX_BUFFER)) begin
            rd_mux = rx_buf_r;
        end else if (idx_is(i_paddr, `NBU_IDX_POWER)) begin
            rd_mux = {double_r, fe_view_r, 6'h00};
        end else if (idx_is(i_paddr, `NBU_IDX_OWN_ADDR)) begin
            rd_mux = own_address_value_r;
        end else if (idx_is(i_paddr, `NBU_IDX_OWN_MASK)) begin
            rd_mux = own_address_mask_r;
        end else if (idx_is(i_paddr, `NBU_IDX_BAUD_SRC)) begin
            rd_mux = {6'h00, rx_t2_r, tx_t2_r};
        end else begin
            addr_hit = 1'b0;
        end
    end

    // Read data is captured in the setup cycle so the answer comes from a flop
    // with no wait state.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            prdata_r <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            prdata_r <= {24'h00_0000, rd_mux};
        end
    end

    assign o_prdata  = prdata_r;
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_hit;

    // ****************************************
    // Software configuration
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            own_address_value_r <= `NBU_RST_BYTE;
            own_address_mask_r  <= `NBU_RST_BYTE;
        end else if (wr_en && idx_is(i_paddr, `NBU_IDX_OWN_ADDR)) begin
            own_address_value_r <= i_pwdata[7:0];
        end else if (wr_en && idx_is(i_paddr, `NBU_IDX_OWN_MASK)) begin
            own_address_mask_r <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            double_r  <= 1'b0;
            fe_view_r <= 1'b0;
        end else if (wr_en && idx_is(i_paddr, `NBU_IDX_POWER)) begin
            double_r  <= i_pwdata[`NBU_PWR_DOUBLE];
            fe_view_r <= i_pwdata[`NBU_PWR_FE_VIEW];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            tx_t2_r <= 1'b0;
            rx_t2_r <= 1'b0;
        end else if (wr_en && idx_is(i_paddr, `NBU_IDX_BAUD_SRC)) begin
            tx_t2_r <= i_pwdata[`NBU_SRC_TX_T2];
            rx_t2_r <= i_pwdata[`NBU_SRC_RX_T2];
        end
    end

    logic ctl_wr;
    assign ctl_wr = wr_en & idx_is(i_paddr, `NBU_IDX_CONTROL);

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            mode_hi_r <= 1'b0;
            mode_lo_r <= 1'b0;
            mpe_r     <= 1'b0;
            ren_r     <= 1'b0;
            tb8_r     <= 1'b0;
        end else if (ctl_wr) begin
            if (!fe_view_r) begin
                mode_hi_r <= i_pwdata[`NBU_CTL_MODE_HI];
            end
            mode_lo_r <= i_pwdata[`NBU_CTL_MODE_LO];
            mpe_r     <= i_pwdata[`NBU_CTL_MPE];
            ren_r     <= i_pwdata[`NBU_CTL_REN];
            tb8_r     <= i_pwdata[`NBU_CTL_TB8];
        end
    end

    // ****************************************
    // Baud ticks (16x bit rate)
    // ****************************************
    logic osc_half_r;
    logic t1_half_r;
    logic osc_tick;
    logic t1_tick;
    logic tx_tick;
    logic rx_tick;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            osc_half_r <= 1'b0;
            t1_half_r  <= 1'b0;
        end else begin
            osc_half_r <= ~osc_half_r;
            if (i_timer1_ovf) begin
                t1_half_r <= ~t1_half_r;
            end
        end
    end

    // Doubling picks a tick every cycle (bit rate /16) or every other (/32)
    assign osc_tick = double_r | osc_half_r;
    assign t1_tick  = i_timer1_ovf & (double_r | t1_half_r);

    always_comb begin
        tx_tick = 1'b0;
        rx_tick = 1'b0;
        unique case (mode)
            nbu_pkg::MODE_9FIX: begin
                tx_tick = osc_tick;
                rx_tick = osc_tick;
            end
            nbu_pkg::MODE_8BIT,
            nbu_pkg::MODE_9VAR: begin
                tx_tick = tx_t2_r ? i_timer2_ovf : t1_tick;
                rx_tick = rx_t2_r ? i_timer2_ovf : t1_tick;
            end
            nbu_pkg::MODE_SHIFT: begin
                tx_tick = 1'b0;
                rx_tick = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Transmitter
    // ****************************************
    nbu_pkg::nbu_tx_state_type tx_state_r;
    logic [3:0]                tx_div_r;
    logic [8:0]                tx_sh_r;
    logic                      tx_shifted_r;
    logic                      tx_roll;
    logic                      tx_last;
    logic                      buf_wr;
    logic                      ti_set;

    assign buf_wr  = wr_en & idx_is(i_paddr, `NBU_IDX_BUFFER);
    assign tx_roll = tx_tick & (tx_div_r == `NBU_OVS_LAST);
    // Ninth bit at output, stop bit beside it, zeros beyond
    assign tx_last = tx_shifted_r & tx_sh_r[1] & (tx_sh_r[8:2] == 7'h00);
    assign ti_set  = tx_roll & (tx_state_r == nbu_pkg::TX_DATA) & tx_last;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            tx_div_r <= 4'h0;
        end else if (tx_tick) begin
            tx_div_r <= tx_div_r + 4'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            tx_state_r   <= nbu_pkg::TX_IDLE;
            tx_sh_r      <= 9'h000;
            tx_shifted_r <= 1'b0;
        end else if (buf_wr) begin
            // A write while busy restarts the frame; software should wait for done
            tx_sh_r      <= {tb8_r, i_pwdata[7:0]};
            tx_shifted_r <= 1'b0;
            tx_state_r   <= nbu_pkg::TX_WAIT;
        end else if (tx_roll) begin
            unique case (tx_state_r)
                nbu_pkg::TX_IDLE: begin
                    tx_state_r <= nbu_pkg::TX_IDLE;
                end
                nbu_pkg::TX_WAIT: begin
                    tx_state_r <= nbu_pkg::TX_START;
                end
                nbu_pkg::TX_START: begin
                    tx_state_r <= nbu_pkg::TX_DATA;
                end
                nbu_pkg::TX_DATA: begin
                    tx_sh_r      <= {~tx_shifted_r, tx_sh_r[8:1]};
                    tx_shifted_r <= 1'b1;
                    if (tx_last) begin
                        tx_state_r <= nbu_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    logic txd_r;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            txd_r <= 1'b1;
        end else begin
            unique case (tx_state_r)
                nbu_pkg::TX_START: txd_r <= 1'b0;
                nbu_pkg::TX_DATA:  txd_r <= tx_sh_r[0];
                default:           txd_r <= 1'b1;
            endcase
        end
    end

    assign o_txd = txd_r;

    // ****************************************
    // Receiver
    // ****************************************
    logic                      rxd_meta_r;
    logic                      rxd_r;
    logic                      rxd_prev_r;
    nbu_pkg::nbu_rx_state_type rx_state_r;
    logic [3:0]                rx_cnt_r;
    logic [8:0]                rx_sh_r;
    logic                      samp_a_r;
    logic                      samp_b_r;
    logic                      bit_r;
    logic                      rx_roll;
    logic                      rx_fall;
    logic                      rx_accept;
    logic                      ri_set;
    logic                      fe_set;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rxd_meta_r <= 1'b1;
            rxd_r      <= 1'b1;
        end else begin
            rxd_meta_r <= i_rxd;
            rxd_r      <= rxd_meta_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rxd_prev_r <= 1'b1;
        end else if (rx_tick) begin
            rxd_prev_r <= rxd_r;
        end
    end

    assign rx_fall = rx_tick & rxd_prev_r & ~rxd_r;
    assign rx_roll = rx_tick & (rx_cnt_r == `NBU_OVS_LAST);

    // Three samples per bit; majority latched on the third
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            samp_a_r <= 1'b1;
            samp_b_r <= 1'b1;
            bit_r    <= 1'b1;
        end else if (rx_tick) begin
            if (rx_cnt_r == `NBU_SAMPLE_A) begin
                samp_a_r <= rxd_r;
            end
            if (rx_cnt_r == `NBU_SAMPLE_B) begin
                samp_b_r <= rxd_r;
            end
            if (rx_cnt_r == `NBU_SAMPLE_C) begin
                bit_r <= (samp_a_r & samp_b_r) | (samp_a_r & rxd_r) | (samp_b_r & rxd_r);
            end
        end
    end

    // Mode 1 reuses the ninth slot for the stop bit, so one test serves both
    assign rx_accept = ~ri_r & (~mpe_r
                       | (bit_r & addr_match(rx_sh_r[8:1], own_address_value_r,
                                             own_address_mask_r)));

    assign ri_set = (rx_state_r == nbu_pkg::RX_BITS) & rx_roll & ~rx_sh_r[0] & rx_accept;

    always_comb begin
        fe_set = 1'b0;
        if (rx_roll && !bit_r) begin
            if (rx_state_r == nbu_pkg::RX_STOP) begin
                fe_set = 1'b1;
            end else if (rx_state_r == nbu_pkg::RX_BITS && !rx_sh_r[0]
                         && mode == nbu_pkg::MODE_8BIT) begin
                fe_set = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rx_state_r <= nbu_pkg::RX_HUNT;
            rx_cnt_r   <= 4'h0;
            rx_sh_r    <= `NBU_RX_PRELOAD;
        end else begin
            unique case (rx_state_r)
                nbu_pkg::RX_HUNT: begin
                    if (rx_fall && ren_r) begin
                        rx_cnt_r   <= 4'h0;
                        rx_sh_r    <= `NBU_RX_PRELOAD;
                        rx_state_r <= nbu_pkg::RX_BITS;
                    end
                end
                nbu_pkg::RX_BITS: begin
                    if (rx_tick) begin
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                    end
                    if (rx_roll) begin
                        if (rx_sh_r == `NBU_RX_PRELOAD && bit_r) begin
                            rx_state_r <= nbu_pkg::RX_HUNT;
                        end else if (!rx_sh_r[0]) begin
                            // Final shift; mode 1 just took its stop bit
                            rx_sh_r    <= {bit_r, rx_sh_r[8:1]};
                            rx_state_r <= (mode == nbu_pkg::MODE_8BIT) ?
                                          nbu_pkg::RX_HUNT : nbu_pkg::RX_STOP;
                        end else begin
                            rx_sh_r <= {bit_r, rx_sh_r[8:1]};
                        end
                    end
                end
                nbu_pkg::RX_STOP: begin
                    if (rx_tick) begin
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                    end
                    if (rx_roll) begin
                        rx_state_r <= nbu_pkg::RX_HUNT;
                    end
                end
                default: begin
                    rx_state_r <= nbu_pkg::RX_HUNT;
                end
            endcase
        end
    end

    // Stop bit value lands in rb8_r in mode 1 only; otherwise it is not involved here
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rx_buf_r <= 8'h00;
            rb8_r    <= 1'b0;
        end else if (ri_set) begin
            rx_buf_r <= rx_sh_r[8:1];
            rb8_r    <= bit_r;
        end else if (ctl_wr) begin
            rb8_r <= i_pwdata[`NBU_CTL_RB8];
        end
    end

    // ****************************************
    // Event flags: hardware set wins over software write
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ti_r <= 1'b0;
            ri_r <= 1'b0;
            fe_r <= 1'b0;
        end else begin
            if (ti_set) begin
                ti_r <= 1'b1;
            end else if (ctl_wr) begin
                ti_r <= i_pwdata[`NBU_CTL_TI];
            end
            if (ri_set) begin
                ri_r <= 1'b1;
            end else if (ctl_wr) begin
                ri_r <= i_pwdata[`NBU_CTL_RI];
            end
            if (fe_set) begin
                fe_r <= 1'b1;
            end else if (ctl_wr && fe_view_r) begin
                fe_r <= i_pwdata[`NBU_CTL_MODE_HI];
            end
        end
    end

endmodule

//--- nbu_uart_props.sv
`include "nbu_cfg.svh"

module nbu_uart_props (
    // Bus
    input wire logic                   i_clk,
    input wire logic                   i_nrst,
    input wire logic                   i_psel,
    input wire logic                   i_penable,
    input wire logic                   i_pwrite,
    input wire logic [`NBU_ADDR_W-1:0] i_paddr,
    input wire logic [31:0]            i_pwdata,
    input wire logic [31:0]            o_prdata,
    input wire logic                   o_pready,
    input wire logic                   o_pslverr,
    // Line
    input wire logic                   o_txd
);
    logic [9:0] idx;
    logic       acc;
    logic       rd_su;
    logic       mapped;
    logic [7:0] own_r;
    logic [7:0] msk_r;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    assign idx    = i_paddr[11:2];
    assign acc    = i_psel && i_penable;
    assign rd_su  = i_psel && !i_penable && !i_pwrite;
    assign mapped = idx inside {`NBU_IDX_POWER, `NBU_IDX_CONTROL, `NBU_IDX_BUFFER,
                                `NBU_IDX_OWN_ADDR, `NBU_IDX_OWN_MASK, `NBU_IDX_BAUD_SRC};

    // Shadows of the address registers, zero after reset
    always_ff @(posedge i_clk)
        if (!i_nrst)
            own_r <= 8'h00;
        else if (acc && i_pwrite && idx == `NBU_IDX_OWN_ADDR)
            own_r <= i_pwdata[7:0];
    always_ff @(posedge i_clk)
        if (!i_nrst)
            msk_r <= 8'h00;
        else if (acc && i_pwrite && idx == `NBU_IDX_OWN_MASK)
            msk_r <= i_pwdata[7:0];

    a_own_readback: assert property (
        rd_su && idx == `NBU_IDX_OWN_ADDR |=> o_prdata[7:0] == own_r)
        else $error("own address readback wrong");
    a_mask_readback: assert property (
        rd_su && idx == `NBU_IDX_OWN_MASK |=> o_prdata[7:0] == msk_r)
        else $error("mask readback wrong");
    a_unmapped_err: assert property (acc && !mapped |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_access_only: assert property (o_pslverr |-> acc)
        else $error("error outside access phase");
    a_ready_zero_wait: assert property (acc |-> o_pready)
        else $error("wait state inserted");
    // A bit lasts 16 ticks and a tick is at most one clock
    a_low_bit_hold: assert property ($fell(o_txd) |-> !o_txd [*8])
        else $error("low level on line too short");
    a_high_bit_hold: assert property ($rose(o_txd) |-> o_txd [*8])
        else $error("high level on line too short");
    a_idle_after_reset: assert property ($rose(i_nrst) |-> o_txd [*2])
        else $error("line not idle after reset");
endmodule

bind nbu_uart nbu_uart_props u_props (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_txd(o_txd)
);

//--- nbu_far_node.sv
module nbu_far_node (
    // Clock and lines
    input  wire logic   i_clk,
    input  wire logic   i_txd,
    output logic        o_rxd,
    // Last frame taken, start bit in bit 0
    output logic [10:0] o_got
);
    timeunit 1ns;
    timeprecision 1ps;

    // Line has a pull-up, so idle reads high
    initial o_rxd = 1'b1;

    task automatic send(input logic [7:0] d, input logic b9, input logic stp);
        logic [10:0] f;
        f = {stp, b9, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            o_rxd <= f[i];
            repeat (16) @(posedge i_clk);
        end
        o_rxd <= 1'b1;
    endtask

    // Mid-bit sampling tolerates the sender's rollover jitter
    task automatic take();
        @(negedge i_txd);
        repeat (8) @(posedge i_clk);
        for (int i = 0; i < 11; i++) begin
            o_got[i] = i_txd;
            repeat (16) @(posedge i_clk);
        end
    endtask
endmodule

//--- nine_bit_uart_addr_match_test.sv
`include "nbu_cfg.svh"

module nine_bit_uart_addr_match_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clk;
    logic        i_nrst;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        rxd;
    logic        o_txd;
    logic [10:0] got;
    logic [31:0] rd;
    logic [31:0] ctl;
    logic        err;
    logic [26:0] row;
    logic [7:0]  last;
    int          n_errors;
    int          n_checks;
    int          cyc;
    // Own address, mask, byte, ninth bit, filter on, accepted
    logic [26:0] rows [6] = '{
        {8'h00, 8'h00, 8'h5a, 1'b0, 1'b0, 1'b1}, {8'hc0, 8'hfd, 8'hc2, 1'b1, 1'b1, 1'b1},
        {8'hc0, 8'hfd, 8'hc1, 1'b1, 1'b1, 1'b0}, {8'hc0, 8'hfd, 8'hff, 1'b1, 1'b1, 1'b1},
        {8'hc0, 8'hfd, 8'hc0, 1'b0, 1'b1, 1'b0}, {8'hc0, 8'hfd, 8'h37, 1'b0, 1'b0, 1'b1}};

    nbu_uart u_dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_timer1_ovf(1'b0), .i_timer2_ovf(1'b0), .i_rxd(rxd), .o_txd(o_txd));
    nbu_far_node u_far (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd), .o_got(got));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= {24'h0, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rx_check(input logic [7:0] d, input logic b9, input logic [1:0] fe_ri);
        repeat (32) @(posedge i_clk);
        apb(1'b0, `NBU_IDX_CONTROL, 8'h00);
        ctl = rd;
        apb(1'b0, `NBU_IDX_BUFFER, 8'h00);
        check({22'h0, ctl[7], ctl[0], rd[7:0]}, {22'h0, fe_ri, d});
        if (fe_ri[0])
            check({31'h0, ctl[2]}, {31'h0, b9});
    endtask

    initial begin
        n_errors = 0;
        n_checks = 0;
        cyc = 0;
        {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'b1;
        apb(1'b0, `NBU_IDX_OWN_ADDR, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, `NBU_IDX_OWN_MASK, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, 10'h3ff, 8'h00);
        check({31'h0, err}, 32'h1);
        // Mode 2 at one tick per clock, then make bit 7 the error flag
        apb(1'b1, `NBU_IDX_POWER, 8'h80);
        apb(1'b1, `NBU_IDX_CONTROL, 8'h90);
        apb(1'b1, `NBU_IDX_POWER, 8'hc0);
        last = 8'h00;
        foreach (rows[i]) begin
            row = rows[i];
            // A refused frame leaves the buffer at the last accepted byte
            if (row[0])
                last = row[10:3];
            apb(1'b1, `NBU_IDX_OWN_ADDR, row[26:19]);
            apb(1'b1, `NBU_IDX_OWN_MASK, row[18:11]);
            apb(1'b1, `NBU_IDX_CONTROL, {2'b00, row[1], 5'h10});
            u_far.send(row[10:3], row[2], 1'b1);
            rx_check(last, row[2], {1'b0, row[0]});
        end
        // Receive flag still set: the next frame is lost
        u_far.send(8'h99, 1'b1, 1'b1);
        rx_check(8'h37, 1'b0, 2'b01);
        // Missing stop bit: data still taken, error flag set
        apb(1'b1, `NBU_IDX_CONTROL, 8'h10);
        u_far.send(8'h3c, 1'b1, 1'b0);
        rx_check(8'h3c, 1'b1, 2'b11);
        apb(1'b1, `NBU_IDX_CONTROL, 8'h90);
        // Short low glitch: must be dropped as a false start
        u_far.o_rxd <= 1'b0;
        repeat (4) @(posedge i_clk);
        u_far.o_rxd <= 1'b1;
        repeat (40) @(posedge i_clk);
        u_far.send(8'h42, 1'b0, 1'b1);
        rx_check(8'h42, 1'b0, 2'b11);
        apb(1'b1, `NBU_IDX_POWER, 8'h80);
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, `NBU_IDX_CONTROL, {4'h9, b[0], 3'h0});
            fork
                u_far.take();
                apb(1'b1, `NBU_IDX_BUFFER, 8'ha5 ^ {8{b[0]}});
            join
            check({21'h0, got}, {21'h0, 1'b1, b[0], 8'ha5 ^ {8{b[0]}}, 1'b0});
            apb(1'b0, `NBU_IDX_CONTROL, 8'h00);
            check({30'h0, rd[7], rd[1]}, 32'h3);
        end
        print_verdict();
    end
endmodule
